/* testbench/lsfc_chain_model.sv */
// Predecessor controller of the chain: its sync waveform on a shared link clock
`timescale 1ns/10ps
module lsfc_chain_model #(
	parameter int PER = 256
)(
	// Shared link clock and reset
	input  wire logic clk_link_i,
	input  wire logic rst_n_i,
	// Sync output of the predecessor
	output logic      wave_o
);
	//------------------------------------------------------------
	// Square wave, half period high
	//------------------------------------------------------------
	logic [15:0] cnt_ff;

	// Launched on the shared clock, so both ends agree on the phase origin
	always_ff @(posedge clk_link_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_ff <= 16'h0000;
		end else begin
			cnt_ff <= (cnt_ff == 16'(PER - 1)) ? 16'h0000 : cnt_ff + 16'h0001;
		end
	end
	assign wave_o = (cnt_ff < 16'(PER / 2));
endmodule

/* testbench/test_lsfc_top.sv */
// Self-checking bench for the lamp dimming, chain sync and fault control block
`timescale 1ns/10ps
module test_lsfc_top;
	import lsfc_pkg::*;
	//------------------------------------------------------------
	// Signals
	//------------------------------------------------------------
	localparam int PER = 256;
	logic        clk_sys_i, rst_n_i, clk_sw_link_i, clk_dim_link_i;
	logic        shutdown_n_i, uvlo_i, dim_source_sel_i, brightness_at_supply_i;
	logic [6:0]  brightness_level_i;
	logic        phase_step_sel_hi_i, phase_step_sel_lo_i, lamp_lit_i;
	logic        dim_sync_in_i, switching_freq_in_i, dimming_freq_in_i, switching_osc_i;
	logic        lamp_current_low_i, sec_overvolt_i, sec_current_high_i;
	logic [1:0]  drain_overcurrent_i, high_side_off_o;
	logic        switching_sync_out_o, dimming_sync_out_o, lamp_dim_on_o, gate_enable_o;
	logic        comp_sink_ovp_o, comp_sink_secondary_current_sense_o, regulator_normal_o, fault_latch_o;
	logic        slave_mode_o;
	logic [23:0] fault_timer_o, t;
	int          num_errors, checked;
	int          mul[4] = '{128, 85, 64, 51};

	//------------------------------------------------------------
	// Design and chain neighbours
	//------------------------------------------------------------
	lsfc_top #(.FT_TRIP(24'h00_0200)) dut (.*);
	lsfc_chain_model #(.PER(PER)) sw_prev (.clk_link_i(clk_sw_link_i), .rst_n_i(rst_n_i),
		.wave_o(switching_freq_in_i));
	lsfc_chain_model #(.PER(PER)) dim_prev (.clk_link_i(clk_dim_link_i), .rst_n_i(rst_n_i),
		.wave_o(dimming_freq_in_i));

	// System clock 10 ns, link clocks 64 ns at unrelated phases
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		clk_sw_link_i = 1'b0;
		#7;
		forever #32 clk_sw_link_i = ~clk_sw_link_i;
	end
	initial begin
		clk_dim_link_i = 1'b0;
		#23.3;
		forever #32 clk_dim_link_i = ~clk_dim_link_i;
	end

	//------------------------------------------------------------
	// Tasks
	//------------------------------------------------------------
	task automatic chk(input logic ok, input string msg);
		checked++;
		if (ok !== 1'b1) begin
			$display("CHECK FAILED %0t %s", $time, msg);
			num_errors++;
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	// Bounded wait; a hang ends the run at once
	task automatic wait_lvl(ref logic s, input logic v, input int n, input string msg);
		int k;
		k = 0;
		while (s !== v && k < n) begin
			@(negedge clk_sys_i);
			k++;
		end
		if (s !== v) begin
			chk(1'b0, msg);
			results();
		end
	endtask
	// Delay from a rise of a to the next rise of b, within sync latency
	task automatic meas(ref logic a, ref logic b, input int exp, input string msg);
		realtime t0;
		wait_lvl(a, 1'b0, 3000, msg);
		wait_lvl(a, 1'b1, 3000, msg);
		t0 = $realtime;
		wait_lvl(b, 1'b0, 3000, msg);
		wait_lvl(b, 1'b1, 3000, msg);
		chk($realtime - t0 >= exp - 70 && $realtime - t0 <= exp + 450, msg);
	endtask
	task automatic results;
		$display("Checks made %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	//------------------------------------------------------------
	// Main sequence
	//------------------------------------------------------------
	initial begin
		{uvlo_i, dim_source_sel_i, brightness_at_supply_i, brightness_level_i,
			phase_step_sel_hi_i, phase_step_sel_lo_i, lamp_lit_i, dim_sync_in_i,
			switching_osc_i, lamp_current_low_i, sec_overvolt_i, sec_current_high_i,
			drain_overcurrent_i, rst_n_i} = '0;
		shutdown_n_i = 1'b1;
		num_errors = 0;
		checked = 0;
		cyc(10);
		chk(gate_enable_o === 1'b0 && fault_latch_o === 1'b0, "reset state");
		rst_n_i = 1'b1;
		cyc(4);
		chk(gate_enable_o === 1'b1 && high_side_off_o === 2'b00, "gates up");
		chk(regulator_normal_o === 1'b1, "regulator level");
		// Overvoltage sink follows its comparator
		sec_overvolt_i = 1'b1;
		cyc(3);
		chk(comp_sink_ovp_o === 1'b1, "ovp sink on");
		sec_overvolt_i = 1'b0;
		cyc(3);
		chk(comp_sink_ovp_o === 1'b0, "ovp sink off");
		// Each side's overcurrent kills the other side's high switch
		for (int i = 1; i < 3; i++) begin
			drain_overcurrent_i = 2'(i);
			cyc(3);
			chk(high_side_off_o === {drain_overcurrent_i[0], drain_overcurrent_i[1]}, "cross");
		end
		drain_overcurrent_i = 2'b00;
		// Secondary overcurrent: sink and fast weight, cleared when it goes
		sec_current_high_i = 1'b1;
		cyc(3);
		t = fault_timer_o;
		cyc(1);
		chk(comp_sink_secondary_current_sense_o === 1'b1, "secondary_current_sense sink");
		chk(fault_timer_o === t + 24'h00_007E, "fast weight");
		sec_current_high_i = 1'b0;
		cyc(3);
		chk(fault_timer_o === 24'h00_0000 && fault_latch_o === 1'b0, "timer clear");
		// Lamp out: slow weight, trip exactly at the terminal count
		lamp_current_low_i = 1'b1;
		cyc(3);
		t = fault_timer_o;
		cyc(1);
		chk(fault_timer_o === t + 24'h00_0001, "slow weight");
		cyc(500);
		chk(fault_latch_o === 1'b0, "no early trip");
		wait_lvl(fault_latch_o, 1'b1, 100, "lamp-out trip");
		chk(fault_timer_o === 24'h00_0200 && gate_enable_o === 1'b0, "trip count");
		chk(high_side_off_o === 2'b11 && lamp_dim_on_o === 1'b0, "stage off");
		lamp_current_low_i = 1'b0;
		cyc(20);
		chk(fault_latch_o === 1'b1 && regulator_normal_o === 1'b1, "latch holds");
		// Shutdown keeps the latch clear even with the fault still present
		shutdown_n_i = 1'b0;
		lamp_current_low_i = 1'b1;
		cyc(600);
		chk(fault_latch_o === 1'b0 && fault_timer_o === 24'h00_0000, "held clear");
		chk(gate_enable_o === 1'b0 && regulator_normal_o === 1'b0, "shut down");
		lamp_current_low_i = 1'b0;
		shutdown_n_i = 1'b1;
		cyc(3);
		chk(gate_enable_o === 1'b1, "restart");
		// Fast trip, then undervoltage clears it
		sec_current_high_i = 1'b1;
		wait_lvl(fault_latch_o, 1'b1, 12, "secondary_current_sense trip");
		uvlo_i = 1'b1;
		sec_current_high_i = 1'b0;
		cyc(3);
		chk(fault_latch_o === 1'b0 && gate_enable_o === 1'b0, "uvlo");
		chk(high_side_off_o === 2'b11, "uvlo gates");
		uvlo_i = 1'b0;
		cyc(3);
		// Master passes its own switching wave at zero phase
		lamp_lit_i = 1'b1;
		switching_osc_i = 1'b1;
		wait_lvl(switching_sync_out_o, 1'b1, 40, "master rise");
		switching_osc_i = 1'b0;
		wait_lvl(switching_sync_out_o, 1'b0, 40, "master fall");
		// External dimming with the level at full, so following it is visible
		dim_source_sel_i = 1'b1;
		brightness_level_i = 7'h7F;
		// Period shortened to keep the run short; the block never polices it
		repeat (3) begin
			dim_sync_in_i = 1'b1;
			cyc(1000);
			dim_sync_in_i = 1'b0;
			cyc(1000);
		end
		dim_sync_in_i = 1'b1;
		cyc(100);
		chk(lamp_dim_on_o === 1'b1, "ext on");
		dim_sync_in_i = 1'b0;
		cyc(50);
		chk(lamp_dim_on_o === 1'b1, "clamp hold");
		cyc(150);
		chk(lamp_dim_on_o === 1'b0, "clamp end");
		cyc(1700);
		dim_sync_in_i = 1'b1;
		cyc(2500);
		chk(lamp_dim_on_o === 1'b1, "full duty");
		// Slave: both waveforms lag the predecessor by the strapped step
		dim_sync_in_i = 1'b0;
		dim_source_sel_i = 1'b0;
		brightness_at_supply_i = 1'b1;
		cyc(3);
		chk(slave_mode_o === 1'b1, "slave strap");
		// Slave before the lamp is lit still runs on its local oscillators
		lamp_lit_i = 1'b0;
		switching_osc_i = 1'b1;
		cyc(4);
		chk(switching_sync_out_o === 1'b1, "startup local high");
		switching_osc_i = 1'b0;
		cyc(4);
		chk(switching_sync_out_o === 1'b0 && dimming_sync_out_o === 1'b1, "startup local low");
		lamp_lit_i = 1'b1;
		for (int s = 0; s < 4; s++) begin
			{phase_step_sel_hi_i, phase_step_sel_lo_i} = 2'(s);
			cyc(3300);
			meas(dimming_freq_in_i, dimming_sync_out_o, PER * mul[s] / 4, "dim lag");
			meas(switching_freq_in_i, switching_sync_out_o, PER * mul[s] / 4, "sw lag");
		end
		results();
	end
endmodule

/* verilog/lsfc_phase.sv */
// Phase-shifted copy of a chained sync waveform, on the link clock
`timescale 1ns/10ps
module lsfc_phase
	import lsfc_pkg::*;
(
	// Link clock and reset
	input  wire logic clk_link_i,
	input  wire logic rst_n_i,
	// Waveform from predecessor, controls from system domain
	input  wire logic wave_i,
	input  wire logic enable_i,
	input  wire logic step_hi_i,
	input  wire logic step_lo_i,
	// Shifted waveform
	output logic      wave_o
);

	typedef struct packed {
		logic [3:0]      syn1;
		logic [3:0]      syn2;
		logic            prev;
		logic [PH_W-1:0] cnt;
		logic [PH_W-1:0] per;
		logic [PH_W-1:0] fall;
		logic            out;
	} lsfc_ph_state_type;

	lsfc_ph_state_type st_ff;
	lsfc_ph_state_type nxt_st;
	logic [7:0]        mul;
	logic [PH_W+7:0]   prod;
	logic [PH_W-1:0]   off;
	logic [PH_W-1:0]   pos;
	logic              w;
	logic              rise;

	// Period is learned from rise to rise, the fall time within it; the
	// output replays the last period delayed by the step. Lost sync or a
	// steady level falls back to the plain input.
	always_comb begin
		nxt_st      = st_ff;
		nxt_st.syn1 = {step_lo_i, step_hi_i, enable_i, wave_i};
		nxt_st.syn2 = st_ff.syn1;
		w           = st_ff.syn2[0];
		rise        = w & ~st_ff.prev;
		unique case ({st_ff.syn2[2], st_ff.syn2[3]})
			2'b00: mul = PH_MUL_180;
			2'b01: mul = PH_MUL_120;
			2'b10: mul = PH_MUL_90;
			2'b11: mul = PH_MUL_72;
		endcase
		prod = (PH_W+8)'(st_ff.per) * (PH_W+8)'(mul);
		off  = prod[PH_W+7:8];
		if (st_ff.cnt >= off) begin
			pos = st_ff.cnt - off;
		end else begin
			pos = st_ff.cnt + st_ff.per - off;
		end
		nxt_st.prev = w;
		if (rise) begin
			nxt_st.cnt = '0;
			nxt_st.per = st_ff.cnt + PH_W'(1);
		end else if (st_ff.cnt != '1) begin
			nxt_st.cnt = st_ff.cnt + PH_W'(1);
		end
		if (~w & st_ff.prev) begin
			nxt_st.fall = st_ff.cnt;
		end
		if (st_ff.syn2[1] && st_ff.per != '0 && st_ff.cnt <= st_ff.per) begin
			nxt_st.out = pos < st_ff.fall;
		end else begin
			nxt_st.out = w;
		end
	end

	// State register
	always_ff @(posedge clk_link_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign wave_o = st_ff.out;

endmodule

/* verilog/lsfc_pkg.sv */
// Shared constants for the lamp dimming, chain sync and fault control block
package lsfc_pkg;

	//--------------------------------------------------------------
	// Fault timer
	//--------------------------------------------------------------
	localparam int          FT_W        = 24;
	localparam logic [23:0] FT_SLOW_INC = 24'h00_0001;
	localparam logic [23:0] FT_FAST_INC = 24'h00_007E;
	localparam logic [23:0] FT_TRIP_DEF = 24'h40_0000;

	//--------------------------------------------------------------
	// Dimming oscillator and brightness
	//--------------------------------------------------------------
	localparam int          CLK_HZ      = 100_000_000;
	localparam int          DIM_HZ      = 208;
	localparam int          DIM_STEPS   = 128;
	localparam logic [11:0] DIM_STEP_CYC = 12'(CLK_HZ / (DIM_HZ * DIM_STEPS) - 1);
	localparam logic [6:0]  BRT_MIN     = 7'h0C;
	localparam logic [28:0] EXT_MIN_MUL = 29'h0000_00CD;
	localparam int          EXT_MIN_SH  = 11;

	//--------------------------------------------------------------
	// Phase step multipliers, fraction of period over 256
	//--------------------------------------------------------------
	localparam logic [7:0]  PH_MUL_180  = 8'h80;
	localparam logic [7:0]  PH_MUL_120  = 8'h55;
	localparam logic [7:0]  PH_MUL_90   = 8'h40;
	localparam logic [7:0]  PH_MUL_72   = 8'h33;
	localparam int          PH_W        = 20;

	//--------------------------------------------------------------
	// Bit positions in the synchronised pin vector
	//--------------------------------------------------------------
	localparam int P_SHUTDOWN_N = 0;
	localparam int P_UVLO = 1;
	localparam int P_SEL  = 2;
	localparam int P_SLV  = 3;
	localparam int P_PSHI = 4;
	localparam int P_PSLO = 5;
	localparam int P_LIT  = 6;
	localparam int P_DSYN = 7;
	localparam int P_SWOS = 8;
	localparam int P_LOW  = 9;
	localparam int P_OVP  = 10;
	localparam int P_SECONDARY_CURRENT_SENSE = 11;
	localparam int P_OC0  = 12;
	localparam int P_OC1  = 13;
	localparam int P_SWSH = 14;
	localparam int P_DMSH = 15;
	localparam int P_LVL  = 16;
	localparam int SYN_W  = 23;

endpackage

/* verilog/lsfc_top.sv */
// Dimming source select, chain sync and fault protection of the inverter
`timescale 1ns/10ps
module lsfc_top
	import lsfc_pkg::*;
#(
	parameter logic [23:0] FT_TRIP = FT_TRIP_DEF
)(
	// System clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       rst_n_i,
	// Chain link clocks shared with neighbours
	input  wire logic       clk_sw_link_i,
	input  wire logic       clk_dim_link_i,
	// Power and mode straps
	input  wire logic       shutdown_n_i,
	input  wire logic       uvlo_i,
	input  wire logic       dim_source_sel_i,
	input  wire logic       brightness_at_supply_i,
	input  wire logic [6:0] brightness_level_i,
	input  wire logic       phase_step_sel_hi_i,
	input  wire logic       phase_step_sel_lo_i,
	input  wire logic       lamp_lit_i,
	// Sync waveforms
	input  wire logic       dim_sync_in_i,
	input  wire logic       switching_freq_in_i,
	input  wire logic       dimming_freq_in_i,
	input  wire logic       switching_osc_i,
	// Comparator results
	input  wire logic       lamp_current_low_i,
	input  wire logic       sec_overvolt_i,
	input  wire logic       sec_current_high_i,
	input  wire logic [1:0] drain_overcurrent_i,
	// Chain outputs
	output logic            switching_sync_out_o,
	output logic            dimming_sync_out_o,
	// Power stage and loop control
	output logic            lamp_dim_on_o,
	output logic            gate_enable_o,
	output logic [1:0]      high_side_off_o,
	output logic            comp_sink_ovp_o,
	output logic            comp_sink_secondary_current_sense_o,
	output logic            regulator_normal_o,
	// Status
	output logic            fault_latch_o,
	output logic [23:0]     fault_timer_o,
	output logic            slave_mode_o
);

	//--------------------------------------------------------------
	// State
	//--------------------------------------------------------------
	typedef struct packed {
		logic [SYN_W-1:0] syn1;
		logic [SYN_W-1:0] syn2;
		logic [FT_W-1:0]  ft;
		logic             fault;
		logic [11:0]      dcnt;
		logic [6:0]       dph;
		logic [20:0]      ecnt;
		logic [20:0]      eper;
		logic             eprev;
		logic             en_ph;
		logic             sw_out;
		logic             dim_out;
		logic             lamp_on;
		logic             gate;
		logic [1:0]       hs_off;
		logic             sink_ovp;
		logic             sink_secondary_current_sense;
		logic             reg_ok;
		logic             slave;
	} lsfc_state_type;

	lsfc_state_type   st_ff;
	lsfc_state_type   nxt_st;
	logic [SYN_W-1:0] s;
	logic             active;
	logic             trip;
	logic             slave;
	logic             ext_mode;
	logic             sync_ok;
	logic [6:0]       lvl;
	logic             int_on;
	logic             ext_on;
	logic             own_dim;
	logic [28:0]      min_prod;
	logic [24:0]      ft_sum;
	logic [23:0]      ft_inc;
	logic             sw_shift;
	logic             dim_shift;

	//--------------------------------------------------------------
	// Link-side phase shifters
	//--------------------------------------------------------------
	// One per waveform, each on its own shared chain clock
	lsfc_phase u_sw_phase (
		.clk_link_i (clk_sw_link_i),
		.rst_n_i    (rst_n_i),
		.wave_i     (switching_freq_in_i),
		.enable_i   (st_ff.en_ph),
		.step_hi_i  (phase_step_sel_hi_i),
		.step_lo_i  (phase_step_sel_lo_i),
		.wave_o     (sw_shift)
	);

	lsfc_phase u_dim_phase (
		.clk_link_i (clk_dim_link_i),
		.rst_n_i    (rst_n_i),
		.wave_i     (dimming_freq_in_i),
		.enable_i   (st_ff.en_ph),
		.step_hi_i  (phase_step_sel_hi_i),
		.step_lo_i  (phase_step_sel_lo_i),
		.wave_o     (dim_shift)
	);

	//--------------------------------------------------------------
	// Next-state logic
	//--------------------------------------------------------------
	// All pins and link returns pass two flops; only syn2 is used
	always_comb begin
		nxt_st      = st_ff;
		nxt_st.syn1 = {brightness_level_i, dim_shift, sw_shift,
			drain_overcurrent_i[1], drain_overcurrent_i[0],
			sec_current_high_i, sec_overvolt_i, lamp_current_low_i,
			switching_osc_i, dim_sync_in_i, lamp_lit_i,
			phase_step_sel_lo_i, phase_step_sel_hi_i,
			brightness_at_supply_i, dim_source_sel_i, uvlo_i, shutdown_n_i};
		nxt_st.syn2 = st_ff.syn1;
		s           = st_ff.syn2;

		// Shutdown and undervoltage both act as a hold-reset
		active   = s[P_SHUTDOWN_N] & ~s[P_UVLO];
		trip     = st_ff.ft >= FT_TRIP;

		// Fault latch survives until shutdown or power loss
		nxt_st.fault = active & (st_ff.fault | trip);

		// Weighted saturating fault timer; fast weight wins
		ft_inc = s[P_SECONDARY_CURRENT_SENSE] ? FT_FAST_INC : FT_SLOW_INC;
		ft_sum = {1'b0, st_ff.ft} + {1'b0, ft_inc};
		if (!active) begin
			nxt_st.ft = '0;
		end else if (st_ff.fault) begin
			nxt_st.ft = st_ff.ft;
		end else if (s[P_SECONDARY_CURRENT_SENSE] | s[P_LOW]) begin
			nxt_st.ft = (ft_sum >= {1'b0, FT_TRIP}) ? FT_TRIP : ft_sum[23:0];
		end else begin
			nxt_st.ft = '0;
		end

		// Mode decode; sync and shifting wait for a lit lamp
		slave    = s[P_SLV];
		ext_mode = s[P_SEL] & ~slave;
		sync_ok  = s[P_LIT];
		nxt_st.slave = slave;
		nxt_st.en_ph = slave & sync_ok;

		// Internal dimming oscillator, 128 steps per period
		if (st_ff.dcnt == DIM_STEP_CYC) begin
			nxt_st.dcnt = '0;
			nxt_st.dph  = st_ff.dph + 7'h01;
		end else begin
			nxt_st.dcnt = st_ff.dcnt + 12'h001;
		end
		lvl    = s[P_LVL +: 7];
		lvl    = (lvl < BRT_MIN) ? BRT_MIN : lvl;
		int_on = st_ff.dph <= lvl;

		// External waveform: period from rise to rise, high time
		// stretched to a tenth of the last period at least
		nxt_st.eprev = s[P_DSYN];
		if (s[P_DSYN] & ~st_ff.eprev) begin
			nxt_st.ecnt = '0;
			nxt_st.eper = st_ff.ecnt;
		end else if (st_ff.ecnt != '1) begin
			nxt_st.ecnt = st_ff.ecnt + 21'h00_0001;
		end
		min_prod = 29'(st_ff.eper) * EXT_MIN_MUL;
		ext_on   = s[P_DSYN] | (st_ff.ecnt < 21'(min_prod >> EXT_MIN_SH));

		// Own dimming phase: slave follows shifted master wave
		if (slave & sync_ok) begin
			own_dim = s[P_DMSH];
		end else if (ext_mode & sync_ok) begin
			own_dim = ext_on;
		end else begin
			own_dim = int_on;
		end
		nxt_st.dim_out = own_dim;
		nxt_st.sw_out  = (slave & sync_ok) ? s[P_SWSH] : s[P_SWOS];

		// Gate and loop control outputs
		nxt_st.gate      = active & ~(st_ff.fault | trip);
		nxt_st.lamp_on   = active & ~(st_ff.fault | trip) & own_dim;
		nxt_st.hs_off[0] = s[P_OC1] | ~nxt_st.gate;
		nxt_st.hs_off[1] = s[P_OC0] | ~nxt_st.gate;
		nxt_st.sink_ovp  = active & s[P_OVP];
		nxt_st.sink_secondary_current_sense = active & s[P_SECONDARY_CURRENT_SENSE];
		nxt_st.reg_ok    = s[P_SHUTDOWN_N];
	end

	//--------------------------------------------------------------
	// State register
	//--------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from flops
	assign switching_sync_out_o = st_ff.sw_out;
	assign dimming_sync_out_o   = st_ff.dim_out;
	assign lamp_dim_on_o        = st_ff.lamp_on;
	assign gate_enable_o        = st_ff.gate;
	assign high_side_off_o      = st_ff.hs_off;
	assign comp_sink_ovp_o      = st_ff.sink_ovp;
	assign comp_sink_secondary_current_sense_o     = st_ff.sink_secondary_current_sense;
	assign regulator_normal_o   = st_ff.reg_ok;
	assign fault_latch_o        = st_ff.fault;
	assign fault_timer_o        = st_ff.ft;
	assign slave_mode_o         = st_ff.slave;

	//--------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	// Trip reached while enabled latches within one cycle
	fault_set_a: assert property (
		active && st_ff.ft >= FT_TRIP |=> st_ff.fault && !gate_enable_o ##1 !gate_enable_o)
		else $error("fault latch not set at trip");

	// Latched fault holds while power and enable stay
	fault_hold_a: assert property (
		st_ff.fault && active |=> st_ff.fault && regulator_normal_o)
		else $error("fault latch dropped without shutdown");

	// Shutdown or undervoltage resets latch and timer
	hold_reset_a: assert property (
		!active |=> !st_ff.fault && st_ff.ft == 24'h00_0000)
		else $error("latch or timer not reset while disabled");

	// Slow charge adds exactly one step
	slow_charge_a: assert property (
		active && !st_ff.fault && !s[P_SECONDARY_CURRENT_SENSE] && s[P_LOW] && st_ff.ft < FT_TRIP - 24'h00_0001
		|=> st_ff.ft == $past(st_ff.ft) + FT_SLOW_INC)
		else $error("slow fault charge wrong");

	// Fast charge adds the heavy weight
	fast_charge_a: assert property (
		active && !st_ff.fault && s[P_SECONDARY_CURRENT_SENSE] && st_ff.ft < FT_TRIP - FT_FAST_INC
		|=> st_ff.ft == $past(st_ff.ft) + FT_FAST_INC)
		else $error("fast fault charge wrong");

	// Cause gone before trip clears the timer
	timer_clear_a: assert property (
		active && !st_ff.fault && !s[P_SECONDARY_CURRENT_SENSE] && !s[P_LOW] |=> st_ff.ft == 24'h00_0000)
		else $error("fault timer not cleared");

	// Overvoltage sink follows comparator
	ovp_sink_a: assert property (
		active && s[P_OVP] |=> comp_sink_ovp_o)
		else $error("overvoltage sink missing");

	// Secondary current sink follows comparator
	secondary_current_sense_sink_a: assert property (
		active && s[P_SECONDARY_CURRENT_SENSE] |=> comp_sink_secondary_current_sense_o)
		else $error("secondary current sink missing");

	// Overcurrent on one side kills the other high side
	opp_high_side_a: assert property (
		s[P_OC0] |=> high_side_off_o[1])
		else $error("opposite high side not turned off");

	// Undervoltage removes gate drive
	uvlo_gate_a: assert property (
		s[P_UVLO] |=> !gate_enable_o && !lamp_dim_on_o)
		else $error("gates driven in undervoltage");

	// External mode passes external high level through
	ext_follow_a: assert property (
		ext_mode && sync_ok && s[P_DSYN] |=> dimming_sync_out_o)
		else $error("external dimming not followed");

	// Before lamp lit, the chain output uses local oscillator
	startup_local_a: assert property (
		!s[P_LIT] |=> switching_sync_out_o == $past(s[P_SWOS]))
		else $error("sync used during startup");

	// Slave after lit forwards the shifted master wave
	slave_follow_a: assert property (
		slave && sync_ok |=> dimming_sync_out_o == $past(s[P_DMSH]))
		else $error("slave not following master");

	// Main scenarios
	lamp_out_trip_c: cover property (s[P_LOW] && !s[P_SECONDARY_CURRENT_SENSE] ##1 st_ff.fault);
	secondary_current_sense_trip_c: cover property (s[P_SECONDARY_CURRENT_SENSE] ##1 st_ff.fault);
	ext_clamp_c: cover property (ext_mode && sync_ok && !s[P_DSYN] && ext_on);
	slave_run_c: cover property (slave && sync_ok && dimming_sync_out_o);

endmodule
